// file: verilog/spei_sink_port_irq.sv
// Edge interrupt logic for the four-pin current-sink output port
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "spei_defines.svh"

// Summary of operation
// (RULE_01) Enable bits at 0,1,2,7; others reserved
// (RULE_02) Enable 1 allows, 0 blocks pin interrupts
// (RULE_03) Enable register clears to zero on reset
// (RULE_04) All pins share one interrupt request
// (RULE_05) Polarity 0 selects falling edge interrupt
// (RULE_06) Polarity 1 selects rising edge interrupt
// (RULE_07) Polarity register at 0,1,2,7, resets zero
// (RULE_08) Data 1 pulls pin high, 0 sinks low
// (RULE_09) Sample pins, compare previous, OR enabled edges
module spei_sink_port_irq #(
    parameter int DATA_W = `SPEI_DATA_W
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [7:0] pin_i,
    output logic [7:0] sink_en_o,
    output logic [7:0] pullup_en_o,
    output logic irq_o
);

    // Pins that exist on the port; bits 3 to 6 are reserved
    localparam spei_pkg::spei_byte_t PIN_MASK = `SPEI_PIN_MASK;

    // Elaboration check on the data width
    generate
        if (DATA_W != `SPEI_DATA_W) begin : g_bad_width
            $error("spei_sink_port_irq supports only 8-bit data");
        end
    endgenerate

    // Elaboration check that every port pin fits the data width
    generate
        if ((PIN_MASK >> DATA_W) != `SPEI_ZERO_BYTE) begin : g_bad_pins
            $error("spei_sink_port_irq pin map exceeds the data width");
        end
    endgenerate

    // Register bus request
    spei_pkg::spei_bus_req_t bus;

    // Write decode
    logic wr_data_hit;
    logic wr_enable_hit;
    logic wr_polarity_hit;
    logic wr_mask_hit;

    // Read decode
    logic rd_data_hit;
    logic rd_status_hit;
    logic rd_mask_hit;
    logic rd_level_hit;
    logic rd_wo_hit;

    // Register state
    spei_pkg::spei_byte_t port_data;
    spei_pkg::spei_byte_t next_port_data;
    spei_pkg::spei_byte_t irq_enable;
    spei_pkg::spei_byte_t next_irq_enable;
    spei_pkg::spei_byte_t irq_polarity;
    spei_pkg::spei_byte_t next_irq_polarity;
    spei_pkg::spei_byte_t irq_status;
    spei_pkg::spei_byte_t next_irq_status;
    spei_pkg::spei_byte_t irq_mask;
    spei_pkg::spei_byte_t next_irq_mask;
    spei_pkg::spei_regs_t regs;

    // Pin sampling and edge detection
    spei_pkg::spei_byte_t pin_now;
    spei_pkg::spei_byte_t pin_prev;
    spei_pkg::spei_byte_t next_pin_prev;
    wire spei_pkg::spei_byte_t rise;
    wire spei_pkg::spei_byte_t fall;
    wire spei_pkg::spei_byte_t edge_evt;
    wire spei_pkg::spei_byte_t irq_src;

    // Output flops
    spei_pkg::spei_byte_t sink_en;
    spei_pkg::spei_byte_t next_sink_en;
    spei_pkg::spei_byte_t pullup_en;
    spei_pkg::spei_byte_t next_pullup_en;
    logic irq;
    logic next_irq;

    // Read data path
    spei_pkg::spei_byte_t rdata;
    spei_pkg::spei_byte_t next_rdata;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Gathered register view
    assign regs = '{
        enable: irq_enable,
        polarity: irq_polarity,
        data: port_data,
        status: irq_status,
        mask: irq_mask
    };

    // Write strobe decode
    always_comb begin
        wr_data_hit = 1'h0;
        wr_enable_hit = 1'h0;
        wr_polarity_hit = 1'h0;
        wr_mask_hit = 1'h0;
        if (bus.wr) begin
            unique case (bus.addr)
                `SPEI_OFS_PORT_DATA: begin
                    wr_data_hit = 1'h1;
                end
                `SPEI_OFS_IRQ_ENABLE: begin
                    wr_enable_hit = 1'h1;
                end
                `SPEI_OFS_IRQ_POLARITY: begin
                    wr_polarity_hit = 1'h1;
                end
                `SPEI_OFS_IRQ_MASK: begin
                    wr_mask_hit = 1'h1;
                end
                default: begin
                end
            endcase
        end
    end

    // Read strobe decode; enable and polarity are write only
    always_comb begin
        rd_data_hit = 1'h0;
        rd_status_hit = 1'h0;
        rd_mask_hit = 1'h0;
        rd_level_hit = 1'h0;
        rd_wo_hit = 1'h0;
        if (bus.rd) begin
            unique case (bus.addr)
                `SPEI_OFS_PORT_DATA: begin
                    rd_data_hit = 1'h1;
                end
                `SPEI_OFS_IRQ_ENABLE: begin
                    rd_wo_hit = 1'h1;
                end
                `SPEI_OFS_IRQ_POLARITY: begin
                    rd_wo_hit = 1'h1;
                end
                `SPEI_OFS_IRQ_STATUS: begin
                    rd_status_hit = 1'h1;
                end
                `SPEI_OFS_IRQ_MASK: begin
                    rd_mask_hit = 1'h1;
                end
                `SPEI_OFS_PIN_LEVEL: begin
                    rd_level_hit = 1'h1;
                end
                default: begin
                end
            endcase
        end
    end

    // Pin sampling against the previous cycle
    always_comb begin
        pin_now = pin_i & PIN_MASK; // [RULE_09]
        next_pin_prev = pin_now; // [RULE_09]
    end

    // Register stage for the previous sample
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_prev <= `SPEI_RST_PIN_SAMPLE;
        end else begin
            pin_prev <= next_pin_prev;
        end
    end

    // Per-pin edge detection; reserved positions never fire
    genvar pin_idx;
    generate
        for (pin_idx = 0; pin_idx < DATA_W; pin_idx = pin_idx + 1) begin : g_pin
            if (PIN_MASK[pin_idx]) begin : g_used
                assign rise[pin_idx] = pin_now[pin_idx] & ~pin_prev[pin_idx];
                assign fall[pin_idx] = ~pin_now[pin_idx] & pin_prev[pin_idx];
                assign edge_evt[pin_idx] = irq_enable[pin_idx] // [RULE_02]
                    & (irq_polarity[pin_idx] ? rise[pin_idx] // [RULE_06]
                    : fall[pin_idx]); // [RULE_05]
                assign irq_src[pin_idx] = next_irq_status[pin_idx] & next_irq_mask[pin_idx];
            end else begin : g_reserved
                assign rise[pin_idx] = 1'h0;
                assign fall[pin_idx] = 1'h0;
                assign edge_evt[pin_idx] = 1'h0;
                assign irq_src[pin_idx] = 1'h0;
            end
        end
    endgenerate

    // Port data register: 1 pulls the pin up, 0 turns the sink on
    always_comb begin
        next_port_data = port_data;
        if (wr_data_hit) begin
            next_port_data = bus.wdata;
        end
    end

    // Register stage for the port data
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            port_data <= `SPEI_RST_PORT_DATA;
        end else begin
            port_data <= next_port_data;
        end
    end

    // Interrupt enable register, write only
    always_comb begin
        next_irq_enable = irq_enable;
        if (wr_enable_hit) begin
            next_irq_enable = bus.wdata & PIN_MASK; // [RULE_01]
        end
    end

    // Register stage for the enable bits
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_enable <= `SPEI_RST_IRQ_ENABLE; // [RULE_03]
        end else begin
            irq_enable <= next_irq_enable;
        end
    end

    // Interrupt polarity register, write only
    always_comb begin
        next_irq_polarity = irq_polarity;
        if (wr_polarity_hit) begin
            next_irq_polarity = bus.wdata & PIN_MASK; // [RULE_07]
        end
    end

    // Register stage for the polarity bits
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_polarity <= `SPEI_RST_IRQ_POLARITY; // [RULE_07]
        end else begin
            irq_polarity <= next_irq_polarity;
        end
    end

    // Interrupt mask register; a set bit lets its status through
    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_mask_hit) begin
            next_irq_mask = bus.wdata & PIN_MASK;
        end
    end

    // Register stage for the mask bits
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_mask <= `SPEI_RST_IRQ_MASK;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // Sticky status, cleared by a read of it
    always_comb begin
        next_irq_status = irq_status;
        if (rd_status_hit) begin
            next_irq_status = `SPEI_ZERO_BYTE;
        end
        // A new edge in the clearing cycle wins
        next_irq_status = next_irq_status | edge_evt;
    end

    // Register stage for the status bits
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_status <= `SPEI_RST_IRQ_STATUS;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_comb begin
        next_rdata = `SPEI_ZERO_BYTE;
        if (rd_data_hit) begin
            next_rdata = regs.data;
        end
        if (rd_wo_hit) begin
            next_rdata = `SPEI_ZERO_BYTE;
        end
        if (rd_status_hit) begin
            next_rdata = regs.status;
        end
        if (rd_mask_hit) begin
            next_rdata = regs.mask;
        end
        if (rd_level_hit) begin
            next_rdata = pin_now;
        end
    end

    // Register stage for the read data
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata <= `SPEI_ZERO_BYTE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Output values, taken from next register values so they track the registers
    always_comb begin
        next_sink_en = ~next_port_data & PIN_MASK; // [RULE_08]
        next_pullup_en = next_port_data & PIN_MASK; // [RULE_08]
        next_irq = |irq_src; // [RULE_04]
    end

    // Register stage for the outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sink_en <= `SPEI_RST_SINK_EN;
            pullup_en <= `SPEI_RST_PULLUP_EN;
            irq <= `SPEI_RST_IRQ;
        end else begin
            sink_en <= next_sink_en;
            pullup_en <= next_pullup_en;
            irq <= next_irq;
        end
    end

    // Outputs
    assign rdata_o = rdata;
    assign sink_en_o = sink_en;
    assign pullup_en_o = pullup_en;
    assign irq_o = irq;

endmodule : spei_sink_port_irq

// file: shared/spei_defines.svh
// Register offsets, reset values and field constants for the sink port interrupt block
`ifndef SPEI_DEFINES_SVH
`define SPEI_DEFINES_SVH

`define SPEI_ADDR_W 8
`define SPEI_DATA_W 8
`define SPEI_OFS_PORT_DATA 8'h30
`define SPEI_OFS_IRQ_ENABLE 8'h31
`define SPEI_OFS_IRQ_POLARITY 8'h32
`define SPEI_OFS_IRQ_STATUS 8'h33
`define SPEI_OFS_IRQ_MASK 8'h34
`define SPEI_OFS_PIN_LEVEL 8'h35
`define SPEI_PIN_MASK 8'h87
`define SPEI_RST_IRQ_ENABLE 8'h00
`define SPEI_RST_IRQ_POLARITY 8'h00
`define SPEI_RST_PORT_DATA 8'hFF
`define SPEI_RST_IRQ_STATUS 8'h00
`define SPEI_RST_IRQ_MASK 8'hFF
`define SPEI_RST_PIN_SAMPLE 8'hFF
`define SPEI_ZERO_BYTE 8'h00
`define SPEI_RST_SINK_EN 8'h00
`define SPEI_RST_PULLUP_EN 8'h87
`define SPEI_RST_IRQ 1'h0

`endif

// file: shared/spei_pkg.sv
// Types shared by the sink port interrupt block
package spei_pkg;

    typedef logic [7:0] spei_byte_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spei_bus_req_t;

    typedef struct packed {
        spei_byte_t enable;
        spei_byte_t polarity;
        spei_byte_t data;
        spei_byte_t status;
        spei_byte_t mask;
    } spei_regs_t;

endpackage : spei_pkg

// file: testbench/spei_pin_model.sv
// Outside load on the sink port pins
`timescale 1ns/10ps
module spei_pin_model (
    input wire logic [7:0] pullup_en_i,
    input wire logic [7:0] pull_low_i,
    output logic [7:0] pin_o
);
    assign pin_o = pullup_en_i & ~pull_low_i;
endmodule : spei_pin_model

// file: testbench/spei_sink_port_irq_properties.sv
// Port checker for the sink port interrupt block
`timescale 1ns/10ps
module spei_sink_port_irq_properties (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] pin_i,
    input wire logic [7:0] sink_en_o,
    input wire logic [7:0] pullup_en_o,
    input wire logic irq_o
);
    logic [7:0] pv, ev;
    logic [7:0] r [8];
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    assign ev = r[1] & r[4] & 8'h87 & (pv ^ pin_i) & ~(r[2] ^ pin_i);
    always_ff @(posedge core_clk_i) begin
        pv <= rst_i ? 8'hFF : pin_i;
        if (rst_i) r <= '{4: 8'h87, default: 8'h00};
        else if (wr_i && addr_i[7:3] == 5'h06) r[addr_i[2:0]] <= wdata_i;
    end
    a_sink_inv: assert property ((sink_en_o ^ pullup_en_o) == 8'h87) else $error("sink");
    a_rsv_zero: assert property (pullup_en_o[6:3] == 4'h0) else $error("rsv");
    a_data_wr: assert property (wr_i && addr_i == 8'h30 |=>
        pullup_en_o == ($past(wdata_i) & 8'h87)) else $error("data");
    a_wo_read: assert property (rd_i && addr_i inside {8'h31, 8'h32} |=>
        rdata_o == 8'h00) else $error("wo");
    a_rst_quiet: assert property ($fell(rst_i) |-> !irq_o) else $error("rst irq");
    a_edge_irq: assert property (ev != 8'h00 |=> irq_o) else $error("no irq");
    a_no_cause: assert property (!irq_o && ev == 8'h00 && !(wr_i && addr_i == 8'h34)
        |=> !irq_o) else $error("stray irq");
    a_rd_clear: assert property (rd_i && addr_i == 8'h33 && ev == 8'h00 |=> !irq_o)
        else $error("clear");
    c_edge: cover property (ev != 8'h00);
    c_clear: cover property (rd_i && addr_i == 8'h33 && irq_o);
    c_mask: cover property (wr_i && addr_i == 8'h34);
endmodule : spei_sink_port_irq_properties
bind spei_sink_port_irq spei_sink_port_irq_properties u_props (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pin_i(pin_i), .sink_en_o(sink_en_o), .pullup_en_o(pullup_en_o), .irq_o(irq_o));

// file: testbench/spei_sink_port_irq_bench.sv
// Self-checking bench for the sink port interrupt block
`timescale 1ns/10ps
module spei_sink_port_irq_bench;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, irq;
    logic [7:0] a = 8'h00, d = 8'h00, lo = 8'h00, q, pin, pu, sn;
    int n_fail = 0, num_checks = 0;
    always #20 clk = ~clk;
    spei_sink_port_irq dut (.core_clk_i(clk), .rst_i(rst), .addr_i(a), .wdata_i(d), .wr_i(wr),
        .rd_i(rd), .rdata_o(q), .pin_i(pin), .sink_en_o(sn), .pullup_en_o(pu), .irq_o(irq));
    spei_pin_model ext (.pullup_en_i(pu), .pull_low_i(lo), .pin_o(pin));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        a <= ad;
        d <= dt;
        @(posedge clk);
        wr <= 1'h0;
        rd <= 1'h0;
        #1;
    endtask : bus
    task automatic settle(input logic [7:0] l, input logic i);
        @(posedge clk);
        lo <= l;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, irq}, {7'h00, i});
    endtask : settle
    task automatic t_reset;
        bus(1'h0, 8'h31, 8'h00);
        chk(q, 8'h00);
        bus(1'h0, 8'h32, 8'h00);
        chk(q, 8'h00);
        chk(pu, 8'h87);
        chk(sn, 8'h00);
        bus(1'h0, 8'h30, 8'h00);
        chk(q, 8'hFF);
        bus(1'h0, 8'h35, 8'h00);
        chk(q, 8'h87);
        $display("reset test done");
    endtask : t_reset
    task automatic t_edges;
        bus(1'h1, 8'h31, 8'h78);
        settle(8'h01, 1'h0);
        bus(1'h1, 8'h31, 8'h87);
        settle(8'h87, 1'h1);
        bus(1'h0, 8'h33, 8'h00);
        chk(q, 8'h86);
        settle(8'h87, 1'h0);
        bus(1'h1, 8'h32, 8'h01);
        settle(8'h00, 1'h1);
        bus(1'h0, 8'h33, 8'h00);
        chk(q, 8'h01);
        $display("edge test done");
    endtask : t_edges
    task automatic t_mask;
        bus(1'h1, 8'h34, 8'h00);
        settle(8'h87, 1'h0);
        bus(1'h1, 8'h34, 8'h87);
        settle(8'h87, 1'h1);
        bus(1'h0, 8'h33, 8'h00);
        chk(q, 8'h86);
        bus(1'h1, 8'h30, 8'h00);
        chk(pu, 8'h00);
        chk(sn, 8'h87);
        $display("mask test done");
    endtask : t_mask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_edges();
        t_mask();
        close_out();
    end
    initial begin
        #20000;
        n_fail++;
        close_out();
    end
endmodule : spei_sink_port_irq_bench
